// ### common/hub_port_params.svh
// Register indices, field layouts, codes and timing figures for the downstream port block
`ifndef HUB_PORT_PARAMS_SVH
`define HUB_PORT_PARAMS_SVH

// Register indices; byte address is four times the index
`define HP_IDX_ENABLE    8'h49
`define HP_IDX_SPEED     8'h4a
`define HP_IDX_DRIVE     8'h4b
`define HP_IDX_SE0       8'h4f
`define HP_IDX_LEVEL     8'h50
`define HP_IDX_PULL      8'h51

// Index field of the byte address
`define HP_ADDR_LSB      2
`define HP_ADDR_MSB      9

// Register widths and reset values
`define HP_REG_W         8
`define HP_PORT_FIELD_W  4
`define HP_RESET_BYTE    8'h00
`define HP_RESET_PORTS   4'h0

// AXI4-Lite response codes
`define HP_RESP_OKAY     2'b00
`define HP_RESP_SLVERR   2'b10

// Clock figures
`define HP_CLK_NS        40

`endif

// ### common/hub_port_pkg.sv
// Shared types for the downstream port block
package hub_port_pkg;

   // Two-bit per-port line forcing code
   typedef enum logic [1:0] {
      DRIVE_NORMAL = 2'b00,   // Repeater traffic only
      DRIVE_DIFF1  = 2'b01,   // D+ high, D- low
      DRIVE_DIFF0  = 2'b10,   // D+ low, D- high
      DRIVE_SE0    = 2'b11    // Both lines low
   } drive_code_t;

   // Write channel progress, one-hot
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,       // Collecting address and data
      WR_RESP = 3'b010,       // Response offered
      WR_HOLD = 3'b100        // Spare code, never entered
   } wr_state_t;

endpackage : hub_port_pkg

// ### hdl/hub_downstream_port_control.sv
// Downstream port enable, line forcing and line status with an AXI4-Lite register slave
`include "hub_port_params.svh"

// How it works
// - Enable bit opens port both ways
// - Enabled unsuspended port repeats both directions
// - No full-speed traffic to low-speed ports
// - Enable waits for packet end, else immediate
// - Suspended hub interrupts on any connect change
// - Enable register clears on both resets
// - Non-idle port at EOF2 loses enable
// - Open upstream link at EOF2 disables
// - Two-bit drive field per port, four codes
// - Drive register resets to normal traffic
// - Drive forcing uses speed-matched edge control
// - Pull-down bit per pin forces low
// - Pull-downs unshaped, hold through suspend
// - SE0 flags report per-port SE0
// - Level bit shows D+ above D-
// - Level bit holds through SE0
// - SE0 and level clear on resets
// - Speed bit marks low-speed, picks edges
module hub_downstream_port_control #(
   parameter int   PORTS                = `HP_PORT_FIELD_W,
   parameter int   ADDR_W               = 12,
   parameter logic DRIVE_CLEAR_ON_BUS_RST = 1'b0
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic              clk_en,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Hub state from the repeater and controller
   input  wire logic              usb_bus_reset,
   input  wire logic              hub_suspended,
   input  wire logic              hub_int_enable,
   input  wire logic [PORTS-1:0]  connect_change,
   input  wire logic [PORTS-1:0]  port_suspended,
   input  wire logic              packet_active,
   input  wire logic              packet_full_speed,
   input  wire logic              eof2_strobe,
   input  wire logic [PORTS-1:0]  up_link_open,
   input  wire logic              tx_dp,
   input  wire logic              tx_dm,
   // Downstream pins
   input  wire logic [PORTS-1:0]  dp_in,
   input  wire logic [PORTS-1:0]  dm_in,
   output logic      [PORTS-1:0]  dp_out,
   output logic      [PORTS-1:0]  dp_oe,
   output logic      [PORTS-1:0]  dm_out,
   output logic      [PORTS-1:0]  dm_oe,
   output logic      [PORTS-1:0]  slow_edge,
   output logic      [PORTS-1:0]  edge_shaped,
   // Repeater steering and hub interrupt request
   output logic      [PORTS-1:0]  down_forward,
   output logic      [PORTS-1:0]  up_forward,
   output logic                   hub_int_req
);

   // Register contents
   logic [PORTS-1:0]     downstream_port_enable;     // Live port enables
   logic [PORTS-1:0]     enable_pending;             // Enables waiting for packet end
   logic [PORTS-1:0]     port_speed;                 // One marks a low-speed device
   logic [2*PORTS-1:0]   downstream_drive_control;   // Two bits per port
   logic [2*PORTS-1:0]   downstream_pin_pull_down;   // D- even, D+ odd
   logic [PORTS-1:0]     downstream_se0_flags;       // From line modules
   logic [PORTS-1:0]     downstream_line_level;      // From line modules
   logic [PORTS-1:0]     line_idle;                  // J state per port

   // Synchronised pins
   logic [PORTS-1:0]     dp_sync;
   logic [PORTS-1:0]     dm_sync;

   // Bus slave state
   hub_port_pkg::wr_state_t wr_state;
   logic                 aw_held;                    // Address captured
   logic                 w_held;                     // Data captured
   logic [7:0]           aw_index;                   // Captured register index
   logic [31:0]          w_data;                     // Captured write data
   logic                 w_lane0;                    // Low byte strobe captured
   logic                 wr_fire;                    // Both halves in hand
   logic                 wr_mapped;                  // Captured index decodes
   logic [7:0]           rd_index;                   // Index of current read
   logic [`HP_REG_W-1:0] rd_byte;                    // Decoded read value
   logic                 rd_mapped;                  // Read index decodes

   // Write strobes per register
   logic                 wr_enable_reg;
   logic                 wr_speed_reg;
   logic                 wr_drive_reg;
   logic                 wr_pull_reg;
   logic [PORTS-1:0]     wr_ports;                   // Low field of write data
   logic [2*PORTS-1:0]   wr_pairs;                   // Full byte of write data

   // Babble detection at EOF2
   logic [PORTS-1:0]     babble;

   // Pins arrive from outside the clock domain
   sync_pair #(
      .WIDTH    (2*PORTS)
   ) u_pin_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .async_in ({dp_in, dm_in}),
      .sync_out ({dp_sync, dm_sync})
   );

   // Repeater steering; a port under forcing is kept disabled by firmware
   always_comb begin
      for (int i = 0; i < PORTS; i++) begin
         // Upstream traffic flows down unless full speed meets a slow port
         down_forward[i] = downstream_port_enable[i] & ~port_suspended[i]
                         & packet_active
                         & ~(packet_full_speed & port_speed[i]);
         // Downstream traffic flows up from enabled ports; babble drops the enable
         up_forward[i]   = downstream_port_enable[i] & ~port_suspended[i];
      end
   end

   // Babble: non-idle line or still-open upstream link at EOF2
   always_comb begin
      for (int i = 0; i < PORTS; i++) begin
         babble[i] = eof2_strobe & downstream_port_enable[i]
                   & (~line_idle[i] | up_link_open[i]);
      end
   end

   // One line module per port
   for (genvar p = 0; p < PORTS; p++) begin : g_port
      port_line u_line (
         .ref_clk   (ref_clk),
         .rst_b     (rst_b),
         .clk_en    (clk_en),
         .bus_reset (usb_bus_reset),
         .dp_sync   (dp_sync[p]),
         .dm_sync   (dm_sync[p]),
         .drive     (hub_port_pkg::drive_code_t'(downstream_drive_control[2*p +: 2])),
         .pull_dp   (downstream_pin_pull_down[2*p+1]),
         .pull_dm   (downstream_pin_pull_down[2*p]),
         .forward   (down_forward[p]),
         .tx_dp     (tx_dp),
         .tx_dm     (tx_dm),
         .low_speed (port_speed[p]),
         .dp_out    (dp_out[p]),
         .dp_oe     (dp_oe[p]),
         .dm_out    (dm_out[p]),
         .dm_oe     (dm_oe[p]),
         .slow_edge (slow_edge[p]),
         .shaped    (edge_shaped[p]),
         .se0       (downstream_se0_flags[p]),
         .diff      (downstream_line_level[p]),
         .idle      (line_idle[p])
      );
   end

   // Write decode from the captured halves
   assign wr_fire       = aw_held & w_held & (wr_state == hub_port_pkg::WR_IDLE);
   assign wr_ports      = w_data[PORTS-1:0];
   assign wr_pairs      = w_data[2*PORTS-1:0];
   assign wr_enable_reg = wr_fire & w_lane0 & (aw_index == `HP_IDX_ENABLE);
   assign wr_speed_reg  = wr_fire & w_lane0 & (aw_index == `HP_IDX_SPEED);
   assign wr_drive_reg  = wr_fire & w_lane0 & (aw_index == `HP_IDX_DRIVE);
   assign wr_pull_reg   = wr_fire & w_lane0 & (aw_index == `HP_IDX_PULL);
   assign wr_mapped     = (aw_index == `HP_IDX_ENABLE) | (aw_index == `HP_IDX_SPEED)
                        | (aw_index == `HP_IDX_DRIVE)  | (aw_index == `HP_IDX_PULL)
                        | (aw_index == `HP_IDX_SE0)    | (aw_index == `HP_IDX_LEVEL);

   // Address and data may arrive in either order; each is held until the response
   assign s_axi_awready = ~aw_held & (wr_state == hub_port_pkg::WR_IDLE);
   assign s_axi_wready  = ~w_held & (wr_state == hub_port_pkg::WR_IDLE);

   // Capture write address
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held  <= 1'b0;
         aw_index <= 8'h00;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held  <= 1'b1;
            aw_index <= s_axi_awaddr[`HP_ADDR_MSB:`HP_ADDR_LSB];
         end else if (wr_fire) begin
            aw_held  <= 1'b0;
         end
      end
   end

   // Capture write data; only lane 0 carries register bits
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         w_held  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_lane0 <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held  <= 1'b0;
         end
      end
   end

   // Write response; unmapped index answers SLVERR
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_state     <= hub_port_pkg::WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `HP_RESP_OKAY;
      end else if (clk_en) begin
         unique case (wr_state)
            hub_port_pkg::WR_IDLE: begin
               if (wr_fire) begin
                  wr_state     <= hub_port_pkg::WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_mapped ? `HP_RESP_OKAY : `HP_RESP_SLVERR;
               end
            end
            hub_port_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state     <= hub_port_pkg::WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               // Illegal code: back to idle
               wr_state     <= hub_port_pkg::WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Port enables; clears act at once, sets wait for the bus to go quiet
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         downstream_port_enable <= `HP_RESET_PORTS;
         enable_pending         <= `HP_RESET_PORTS;
      end else if (clk_en) begin
         if (usb_bus_reset) begin
            downstream_port_enable <= `HP_RESET_PORTS;
            enable_pending         <= `HP_RESET_PORTS;
         end else if (wr_enable_reg) begin
            if (packet_active) begin
               // Mid-packet: keep kept bits, park new ones
               downstream_port_enable <= downstream_port_enable & wr_ports & ~babble;
               enable_pending         <= wr_ports & ~downstream_port_enable & ~babble;
            end else begin
               downstream_port_enable <= wr_ports & ~babble;
               enable_pending         <= `HP_RESET_PORTS;
            end
         end else begin
            // Parked enables apply once the packet ends; babble masks only ports already enabled
            if (!packet_active) begin
               downstream_port_enable <= (downstream_port_enable | enable_pending) & ~babble;
               enable_pending         <= `HP_RESET_PORTS;
            end else begin
               downstream_port_enable <= downstream_port_enable & ~babble;
               enable_pending         <= enable_pending & ~babble;
            end
         end
      end
   end

   // Port speed, set by firmware on port reset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_speed <= `HP_RESET_PORTS;
      end else if (clk_en) begin
         if (usb_bus_reset) begin
            port_speed <= `HP_RESET_PORTS;
         end else if (wr_speed_reg) begin
            port_speed <= wr_ports;
         end
      end
   end

   // Drive control; bus-reset clearing is a build option since the two readings differ
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         downstream_drive_control <= `HP_RESET_BYTE;
      end else if (clk_en) begin
         if (usb_bus_reset && DRIVE_CLEAR_ON_BUS_RST) begin
            downstream_drive_control <= `HP_RESET_BYTE;
         end else if (wr_drive_reg) begin
            downstream_drive_control <= wr_pairs;
         end
      end
   end

   // Pin pull-downs survive bus reset and suspend alike
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         downstream_pin_pull_down <= `HP_RESET_BYTE;
      end else if (clk_en) begin
         if (wr_pull_reg) begin
            downstream_pin_pull_down <= wr_pairs;
         end
      end
   end

   // Hub interrupt request while suspended, port enable ignored
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hub_int_req <= 1'b0;
      end else if (clk_en) begin
         hub_int_req <= hub_suspended & hub_int_enable & (|connect_change);
      end
   end

   // Read decode; upper nibble of the one-bit-per-port registers reads zero
   always_comb begin
      rd_byte   = `HP_RESET_BYTE;
      rd_mapped = 1'b1;
      rd_index  = s_axi_araddr[`HP_ADDR_MSB:`HP_ADDR_LSB];
      unique case (rd_index)
         `HP_IDX_ENABLE: rd_byte = {4'h0, downstream_port_enable};
         `HP_IDX_SPEED:  rd_byte = {4'h0, port_speed};
         `HP_IDX_DRIVE:  rd_byte = downstream_drive_control;
         `HP_IDX_SE0:    rd_byte = {4'h0, downstream_se0_flags};
         `HP_IDX_LEVEL:  rd_byte = {4'h0, downstream_line_level};
         `HP_IDX_PULL:   rd_byte = downstream_pin_pull_down;
         default:        rd_mapped = 1'b0;
      endcase
   end

   // Read channel: one read at a time, answered the cycle after acceptance
   assign s_axi_arready = ~s_axi_rvalid;

   // Read data register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `HP_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_mapped ? `HP_RESP_OKAY : `HP_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : hub_downstream_port_control

// ### hdl/port_line.sv
// Per-port line logic: pin drive mux, SE0 flag and held differential level
module port_line (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,
   input  wire logic                     bus_reset,
   input  wire logic                     dp_sync,
   input  wire logic                     dm_sync,
   input  wire hub_port_pkg::drive_code_t drive,
   input  wire logic                     pull_dp,
   input  wire logic                     pull_dm,
   input  wire logic                     forward,
   input  wire logic                     tx_dp,
   input  wire logic                     tx_dm,
   input  wire logic                     low_speed,
   output logic                          dp_out,
   output logic                          dp_oe,
   output logic                          dm_out,
   output logic                          dm_oe,
   output logic                          slow_edge,
   output logic                          shaped,
   output logic                          se0,
   output logic                          diff,
   output logic                          idle
);

   logic forced;   // Drive field asks for a line state

   assign forced = (drive != hub_port_pkg::DRIVE_NORMAL);

   // Idle is J: D+ high for full speed, D- high for low speed
   assign idle = low_speed ? (dm_sync & ~dp_sync) : (dp_sync & ~dm_sync);

   // Line status; SE0 holds the last differential level
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         se0  <= 1'b0;
         diff <= 1'b0;
      end else if (clk_en) begin
         if (bus_reset) begin
            se0  <= 1'b0;
            diff <= 1'b0;
         end else begin
            se0 <= ~dp_sync & ~dm_sync;
            if (dp_sync != dm_sync) begin
               diff <= dp_sync;
            end   // Otherwise hold across SE0
         end
      end
   end

   // Pin drive: pull-down first, then forcing, then repeated traffic
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dp_out    <= 1'b0;
         dm_out    <= 1'b0;
         dp_oe     <= 1'b0;
         dm_oe     <= 1'b0;
         slow_edge <= 1'b0;
         shaped    <= 1'b0;
      end else if (clk_en) begin
         dp_oe  <= pull_dp | forced | forward;
         dm_oe  <= pull_dm | forced | forward;
         dp_out <= pull_dp ? 1'b0 : (forced ? (drive == hub_port_pkg::DRIVE_DIFF1) : tx_dp);
         dm_out <= pull_dm ? 1'b0 : (forced ? (drive == hub_port_pkg::DRIVE_DIFF0) : tx_dm);
         // Raw pull-downs bypass edge shaping
         shaped    <= ~(pull_dp | pull_dm) & (forced | forward);
         slow_edge <= low_speed;
      end
   end

endmodule : port_line

// ### hdl/sync_pair.sv
// Two-stage synchroniser for a bus of pin levels
module sync_pair #(
   parameter int WIDTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_a;   // Metastable stage, read only by stage two

   // Two flops, nothing looks at the first
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_a  <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         stage_a  <= async_in;
         sync_out <= stage_a;
      end
   end

endmodule : sync_pair

// ### verification/hub_port_asserts.sv
// Concurrent checks on the downstream port block ports
module hub_port_asserts (
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        usb_bus_reset,
   input wire logic        hub_suspended,
   input wire logic        hub_int_enable,
   input wire logic [3:0]  connect_change,
   input wire logic [3:0]  port_suspended,
   input wire logic        packet_active,
   input wire logic        eof2_strobe,
   input wire logic [3:0]  up_link_open,
   input wire logic [3:0]  down_forward,
   input wire logic [3:0]  up_forward,
   input wire logic        hub_int_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   chk_int_raise: assert property (
      hub_suspended && hub_int_enable && |connect_change |=> hub_int_req) else $error("int lost");
   chk_int_mask: assert property (
      !hub_int_enable |=> !hub_int_req) else $error("int masked");
   chk_susp_block: assert property (
      (up_forward & port_suspended) == 4'h0) else $error("suspended forward");
   chk_down_subset: assert property (
      (down_forward & ~up_forward) == 4'h0) else $error("down without port");
   chk_down_idle: assert property (
      !packet_active |-> down_forward == 4'h0) else $error("down with no packet");
   chk_bus_clear: assert property (
      usb_bus_reset |=> up_forward == 4'h0) else $error("bus reset kept port");
   chk_link_babble: assert property (
      eof2_strobe |=> (up_forward & $past(up_link_open)) == 4'h0) else $error("babble kept");
   chk_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata");
   cover property (eof2_strobe && |up_link_open);
   cover property (hub_int_req);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : hub_port_asserts

bind hub_downstream_port_control hub_port_asserts i_hub_port_asserts (.*);

// ### verification/tb.sv
// Self-checking bench for the downstream port block
`include "hub_port_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // Byte addresses, four times the index
   localparam logic [11:0] A_EN = {2'h0, `HP_IDX_ENABLE, 2'h0};
   localparam logic [11:0] A_SPD = {2'h0, `HP_IDX_SPEED, 2'h0};
   localparam logic [11:0] A_DRV = {2'h0, `HP_IDX_DRIVE, 2'h0};
   localparam logic [11:0] A_SE0 = {2'h0, `HP_IDX_SE0, 2'h0};
   localparam logic [11:0] A_LVL = {2'h0, `HP_IDX_LEVEL, 2'h0};
   localparam logic [11:0] A_PULL = {2'h0, `HP_IDX_PULL, 2'h0};
   logic        ref_clk, rst_b, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, usb_bus_reset, hub_suspended, hub_int_enable, packet_active;
   logic        packet_full_speed, eof2_strobe, tx_dp, tx_dm, hub_int_req;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0]  s_axi_wstrb, connect_change, port_suspended, up_link_open, dp_in, dm_in;
   logic [3:0]  dp_out, dp_oe, dm_out, dm_oe, slow_edge, edge_shaped, down_forward, up_forward;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
   logic [7:0]  line_st, rnd;
   logic [2:0]  pin0;
   int          errors, num_checks;
   // Port 0 pins, undriven levels masked
   assign pin0 = {dp_oe[0], dp_oe[0] & dp_out[0], dm_oe[0] & dm_out[0]};
   hub_downstream_port_control i_hub_downstream_port_control (.*);
   usb_dev_model i_usb_dev_model (.*);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wt
   // Address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 99);
      chk("bresp", `HP_RESP_OKAY, s_axi_bresp);
      s_axi_bready <= 1'b0;
      if (n >= 99) errors++;
      wt(1);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 99);
      {rd_data, rd_resp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      if (n >= 99) errors++;
      wt(1);
   endtask : rd
   task automatic rc(input string w, input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(w, e, rd_data);
   endtask : rc
   // Expected {oe, D+, D-} for a drive code
   function automatic logic [2:0] drv_exp(input logic [1:0] c);
      return {c != 2'h0, c == 2'h1, c == 2'h2};
   endfunction : drv_exp
   task automatic pulse_eof2;
      eof2_strobe <= 1'b1;
      wt(1);
      {eof2_strobe, up_link_open} <= 5'h00;
      wt(1);
   endtask : pulse_eof2
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   // Watchdog, far beyond the 120 or so cycles used
   initial begin
      #200000;
      errors++;
      report_and_stop;
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rst_b} = '0;
      {usb_bus_reset, hub_suspended, hub_int_enable, packet_active, eof2_strobe} = '0;
      {packet_full_speed, tx_dp, tx_dm, connect_change, port_suspended, up_link_open} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, line_st} = '0;
      {s_axi_wstrb, clk_en} = 5'h1f;
      rnd = 8'($urandom(47506));
      wt(3);
      rst_b <= 1'b1;
      wt(1);
      rc("enable", A_EN, 0);
      rc("speed", A_SPD, 0);
      rc("drive", A_DRV, 0);
      rc("se0", A_SE0, 0);
      rd(12'h000);
      chk("resp", 2'h2, rd_resp);
      $display("reset test done");
      wr(A_EN, rnd);
      rc("enable", A_EN, {28'h0, rnd[3:0]});
      chk("up", rnd[3:0], up_forward);
      port_suspended <= 4'h1;
      wr(A_EN, 8'h00);
      packet_active <= 1'b1;
      wr(A_EN, 8'hff);
      chk("deferred", 4'h0, up_forward);
      packet_active <= 1'b0;
      wt(2);
      chk("applied", 4'he, up_forward);
      port_suspended <= 4'h0;
      up_link_open <= 4'h2;
      pulse_eof2;
      chk("link babble", 4'hd, up_forward);
      $display("enable test done");
      line_st <= 8'h10;
      wt(4);
      rc("level", A_LVL, 32'hb);
      line_st <= 8'h20;
      wt(4);
      rc("se0", A_SE0, 32'h4);
      rc("held", A_LVL, 32'hb);
      pulse_eof2;
      chk("idle babble", 4'h9, up_forward);
      $display("line test done");
      wr(A_EN, 8'h00);
      for (int c = 0; c < 4; c++) begin
         rnd = 8'($urandom);
         wr(A_DRV, {rnd[7:2], c[1:0]});
         wt(2);
         chk("pins", drv_exp(c[1:0]), pin0);
         chk("shaped", c != 0, edge_shaped[0]);
      end
      wr(A_DRV, 8'h01);
      wr(A_PULL, 8'h01);
      wt(2);
      chk("pull", 3'b110, pin0);
      chk("pull oe", 1'b1, dm_oe[0]);
      chk("unshaped", 1'b0, edge_shaped[0]);
      $display("drive test done");
      wr(A_DRV, 8'h00);
      hub_suspended <= 1'b1;
      hub_int_enable <= 1'b1;
      connect_change <= 4'h8;
      wt(1);
      connect_change <= 4'h0;
      @(negedge ref_clk);
      chk("interrupt", 1'b1, hub_int_req);
      wt(1);
      wr(A_EN, 8'h0f);
      usb_bus_reset <= 1'b1;
      wt(1);
      usb_bus_reset <= 1'b0;
      rc("bus reset", A_EN, 0);
      wr(A_SPD, 8'h0a);
      wr(A_EN, 8'h0f);
      {packet_active, packet_full_speed} <= 2'h3;
      wt(1);
      chk("slow edge", 4'ha, slow_edge);
      chk("fs filter", 4'h5, down_forward);
      $display("event test done");
      report_and_stop;
   end
endmodule : tb

// ### verification/usb_dev_model.sv
// Downstream device model: idle, K or SE0 per port, hub drive wins
module usb_dev_model (
   input  wire logic [7:0] line_st,
   input  wire logic [3:0] dp_out,
   input  wire logic [3:0] dp_oe,
   input  wire logic [3:0] dm_out,
   input  wire logic [3:0] dm_oe,
   output logic      [3:0] dp_in,
   output logic      [3:0] dm_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Code 0 is J, 1 is K, 2 is SE0; pull-down resistors make SE0 read low
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         dp_in[p] = dp_oe[p] ? dp_out[p] : (line_st[2*p+:2] == 2'h0);
         dm_in[p] = dm_oe[p] ? dm_out[p] : (line_st[2*p+:2] == 2'h1);
      end
   end
endmodule : usb_dev_model
